// file: verilog/sea_edit.sv
// sea_edit: keypad setpoint editor, passcode access control, APB registers
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - stored setpoints drive sp_o at once, no activation step.
// - keypad store refused with error unless access jumper closed.
// - the jumper never gates APB setpoint writes.
// - an 8-character passcode gates keypad and APB setpoint changes.
// - passcode "0" lifts passcode gating on every interface.
// - other passcode: each interface locked until it presents the match.
// - one access flag per interface, granted independently.
// - lock key clears the keypad access flag.
// - APB writing a wrong passcode to the enable register drops APB access.
// - access flag drops after thirty idle minutes on that interface.
// - help key cycles range, step and edit-method messages automatically.
// - each setpoint has min, max, step; only in-range values store.
// - digit keys and decimal point build the value, leftmost first.
// - escape before enter discards the edit, shows stored value.
// - up key adds one step, wraps past max to min.
// - down key subtracts one step, wraps below min to max.
// - edit stays pending until enter commits it.
// - successful store shows confirmation briefly, then normal display.
// - committed value rounds to nearest step multiple before store.
// - enumeration setpoints step through members with value keys only.
// - out-of-range commit keeps stored value, shows out-of-range message.
module sea_edit import sea_pkg::*; #(
	parameter int              NSP        = 4,
	parameter int              W          = 24,
	parameter logic [NSP*W-1:0] MIN_P     = {NSP{W'(100)}},
	parameter logic [NSP*W-1:0] MAX_P     = {NSP{W'(500000)}},
	parameter logic [NSP*W-1:0] STEP_P    = {NSP{W'(10)}},
	parameter logic [NSP*W-1:0] INIT_P    = {NSP{W'(1000)}},
	parameter logic [NSP-1:0]  ENUM_P     = '0,
	parameter int              TICK_CYC_P = TICK_CYC,
	parameter int              TIMEOUT_P  = TIMEOUT_MS,
	parameter int              FLASH_P    = FLASH_MS,
	parameter int              HELP_P     = HELP_MS
) (
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic                   pready_o,
	output logic      [31:0]       prdata_o,
	output logic                   pslverr_o,
	input  wire sea_key_t          key_i,
	input  wire logic              jumper_i,
	output logic      [W-1:0]      disp_val_o,
	output sea_msg_t               msg_o,
	output logic      [$clog2(NSP)-1:0] sel_o,
	output logic      [NSP*W-1:0]  sp_o,
	output logic                   kbd_acc_o,
	output logic                   com_acc_o
);
	localparam int SW  = $clog2(NSP);
	localparam int TKW = $clog2(TICK_CYC_P);
	localparam int TOW = $clog2(TIMEOUT_P + 1);
	localparam logic [W-1:0] ACC_LIM = W'({W{1'b1}} / 1000);

	if (NSP < 2 || NSP > 64 || W < 8 || W > 32) begin : g_bad
		$error("sea_edit: NSP or W out of range");
	end
	if (TICK_CYC_P < 2 || TIMEOUT_P < 2 || FLASH_P < 1 || HELP_P < 1
		|| FLASH_P > 65535 || HELP_P > 65535) begin : g_badt
		$error("sea_edit: timing parameter out of range");
	end

	sea_st_t                   kst_r;
	sea_msg_t                  msg_r;
	logic [SW-1:0]             sel_r;
	logic [W-1:0]              edit_r;
	logic [W-1:0]              acc_r;
	logic [1:0]                frac_r;
	logic                      dot_r;
	logic                      dig_r;
	logic                      hret_r;
	logic [15:0]               tmr_r;
	logic [8*PASS_CHARS-1:0]   pbuf_r;
	logic [3:0]                pcnt_r;
	logic [8*PASS_CHARS-1:0]   pass_r;
	logic [31:0]               ena_lo_r;
	logic [31:0]               code_lo_r;
	logic [W-1:0]              sp_r [NSP];
	logic [W-1:0]              disp_r;
	logic                      pready_r;
	logic [31:0]               prdata_r;
	logic                      pslverr_r;
	logic [TKW-1:0]            tk_r;
	logic                      tick_r;
	logic [TOW-1:0]            idle_r [N_IF];
	logic                      acc_f_r [N_IF];
	logic                      grant [N_IF];
	logic                      revoke [N_IF];
	logic                      act [N_IF];

	function automatic logic [W-1:0] scale(input logic [W-1:0] v, input logic [1:0] f);
		unique case (f)
			2'd0:    scale = W'(v * W'(100));
			2'd1:    scale = W'(v * W'(10));
			default: scale = v;
		endcase
	endfunction

	// keypad decode and current setpoint limits
	wire             key_v  = key_i.valid;
	wire [4:0]       kc     = key_i.code;
	wire             is_dig = key_v && kc <= K_9;
	wire [W-1:0]     dval   = W'(kc[3:0]);
	wire [W-1:0]     cmin   = MIN_P[sel_r*W +: W];
	wire [W-1:0]     cmax   = MAX_P[sel_r*W +: W];
	wire [W-1:0]     cstep  = STEP_P[sel_r*W +: W];
	wire             cenum  = ENUM_P[sel_r];
	wire [W-1:0]     cur    = sp_r[sel_r];
	wire [W-1:0]     base   = (kst_r == ST_EDIT) ? edit_r : cur;
	wire [W:0]       up_v   = {1'b0, base} + {1'b0, cstep};
	wire [W-1:0]     up_nxt = (up_v > {1'b0, cmax}) ? cmin : up_v[W-1:0];
	wire             dn_wr  = {1'b0, base} < ({1'b0, cmin} + {1'b0, cstep});
	wire [W-1:0]     dn_nxt = dn_wr ? cmax : base - cstep;
	wire [W-1:0]     acc_n  = W'(acc_r * W'(10)) + dval;
	wire [1:0]       frac_n = dot_r ? frac_r + 2'd1 : frac_r;
	wire             dig_ok = dot_r ? (frac_r < 2'(FRAC_DIGITS)) : (acc_r < ACC_LIM);
	// nearest step multiple; half a step rounds up
	wire [W:0]       rsum   = {1'b0, edit_r} + {2'b0, cstep[W-1:1]};
	wire [W:0]       rq     = rsum / {1'b0, cstep};
	wire [W:0]       rnd    = (W+1)'(rq * {1'b0, cstep});
	wire             in_rng = rnd >= {1'b0, cmin} && rnd <= {1'b0, cmax};
	wire             pass_def = (pass_r == PASS_DEFAULT);
	wire             kbd_ok = pass_def || acc_f_r[IF_KBD];
	wire             com_ok = pass_def || acc_f_r[IF_COM];
	wire             k_ent  = key_v && kc == K_ENTER;
	wire             kst_store = kst_r == ST_EDIT && k_ent && jumper_i && kbd_ok && in_rng;

	// APB decode
	wire             acc_ph = psel_i && penable_i && !pready_r;
	wire             apb_go = psel_i && penable_i && pready_r;
	wire             apb_wr = apb_go && pwrite_i;
	wire             sp_hit = paddr_i[11:8] == A_SP_PAGE && paddr_i[1:0] == 2'b00
		&& int'(paddr_i[7:2]) < NSP;
	wire [SW-1:0]    aidx   = paddr_i[2 +: SW];
	wire [W-1:0]     wv     = pwdata_i[W-1:0];
	wire             wrng   = (pwdata_i >> W) == 32'h0
		&& wv >= MIN_P[aidx*W +: W] && wv <= MAX_P[aidx*W +: W];
	wire             known  = sp_hit || paddr_i == A_ENA_LO || paddr_i == A_ENA_HI
		|| paddr_i == A_CODE_LO || paddr_i == A_CODE_HI || paddr_i == A_STATUS;
	wire             refuse = pwrite_i && ((paddr_i == A_CODE_HI && !com_ok)
		|| (sp_hit && (!com_ok || !wrng)));
	wire             berr   = !known || refuse;
	wire [8*PASS_CHARS-1:0] ena_word = {pwdata_i, ena_lo_r};
	logic [31:0]     rdata;

	always_comb begin
		rdata = 32'h0;
		if (paddr_i == A_STATUS) begin
			rdata[SB_JMP]  = jumper_i;
			rdata[SB_DEF]  = pass_def;
			rdata[SB_KACC] = acc_f_r[IF_KBD];
			rdata[SB_CACC] = acc_f_r[IF_COM];
		end else if (sp_hit) begin
			rdata = 32'(sp_r[aidx]);
		end
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= acc_ph;
			if (acc_ph) begin
				prdata_r  <= pwrite_i ? 32'h0 : rdata;
				pslverr_r <= berr;
			end
		end
	end

	// passcode staging and programming; passcode words never read back
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ena_lo_r  <= 32'h0;
			code_lo_r <= 32'h0;
			pass_r    <= PASS_DEFAULT;
		end else if (apb_wr) begin
			if (paddr_i == A_ENA_LO)
				ena_lo_r <= pwdata_i;
			if (paddr_i == A_CODE_LO)
				code_lo_r <= pwdata_i;
			if (paddr_i == A_CODE_HI && com_ok)
				pass_r <= {pwdata_i, code_lo_r};
		end
	end

	// setpoint store: keypad commit wins a same-cycle clash
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			for (int j = 0; j < NSP; j++)
				sp_r[j] <= INIT_P[j*W +: W];
		end else if (kst_store) begin
			sp_r[sel_r] <= rnd[W-1:0];
		end else if (apb_wr && sp_hit && !berr) begin
			sp_r[aidx] <= wv;
		end
	end

	// millisecond time base
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			tk_r   <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= tk_r == TKW'(TICK_CYC_P - 1);
			tk_r   <= (tk_r == TKW'(TICK_CYC_P - 1)) ? '0 : tk_r + 1'b1;
		end
	end

	assign act[IF_KBD]    = key_v;
	assign act[IF_COM]    = apb_go;
	assign grant[IF_KBD]  = kst_r == ST_PASS && k_ent && pbuf_r == pass_r;
	assign revoke[IF_KBD] = key_v && kc == K_LOCK;
	assign grant[IF_COM]  = apb_wr && paddr_i == A_ENA_HI && ena_word == pass_r;
	assign revoke[IF_COM] = apb_wr && paddr_i == A_ENA_HI && ena_word != pass_r;

	// per-interface access flag and idle timer
	for (genvar i = 0; i < N_IF; i++) begin : g_if
		always_ff @(posedge clock_i) begin
			if (!nrst_i) begin
				idle_r[i]  <= '0;
				acc_f_r[i] <= 1'b0;
			end else begin
				if (act[i])
					idle_r[i] <= '0;
				else if (tick_r && idle_r[i] != TOW'(TIMEOUT_P))
					idle_r[i] <= idle_r[i] + 1'b1;
				if (grant[i])
					acc_f_r[i] <= 1'b1;
				else if (revoke[i])
					acc_f_r[i] <= 1'b0;
				else if (tick_r && !act[i] && idle_r[i] == TOW'(TIMEOUT_P - 1))
					acc_f_r[i] <= 1'b0;
			end
		end
	end

	for (genvar j = 0; j < NSP; j++) begin : g_sp
		if (STEP_P[j*W +: W] == '0) begin : g_bad
			$error("sea_edit: zero step");
		end
		assign sp_o[j*W +: W] = sp_r[j];
	end

	// keypad editor
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			kst_r  <= ST_IDLE;
			msg_r  <= MSG_NORMAL;
			sel_r  <= '0;
			edit_r <= '0;
			acc_r  <= '0;
			frac_r <= 2'd0;
			dot_r  <= 1'b0;
			dig_r  <= 1'b0;
			hret_r <= 1'b0;
			tmr_r  <= 16'h0;
			pbuf_r <= '0;
			pcnt_r <= 4'h0;
		end else begin
			unique case (kst_r)
				ST_IDLE, ST_EDIT: if (key_v) begin
					if ((is_dig || kc == K_DOT) && !cenum) begin
						kst_r <= ST_EDIT;
						msg_r <= MSG_EDIT;
						dig_r <= 1'b1;
						if (kst_r == ST_IDLE || !dig_r) begin
							acc_r  <= is_dig ? dval : '0;
							edit_r <= is_dig ? scale(dval, 2'd0) : '0;
							frac_r <= 2'd0;
							dot_r  <= !is_dig;
						end else if (!is_dig) begin
							dot_r <= 1'b1;
						end else if (dig_ok) begin
							acc_r  <= acc_n;
							frac_r <= frac_n;
							edit_r <= scale(acc_n, frac_n);
						end
					end else if (kc == K_UP || kc == K_DOWN) begin
						kst_r  <= ST_EDIT;
						msg_r  <= MSG_EDIT;
						dig_r  <= 1'b0;
						edit_r <= (kc == K_UP) ? up_nxt : dn_nxt;
					end else if (kc == K_HELP) begin
						kst_r  <= ST_HELP;
						msg_r  <= MSG_H_MIN;
						hret_r <= kst_r == ST_EDIT;
						tmr_r  <= 16'(HELP_P - 1);
					end else if (kst_r == ST_EDIT && kc == K_ESC) begin
						kst_r <= ST_IDLE;
						msg_r <= MSG_NORMAL;
					end else if (kst_r == ST_EDIT && kc == K_ENTER) begin
						kst_r <= ST_FLASH;
						tmr_r <= 16'(FLASH_P - 1);
						if (!jumper_i)
							msg_r <= MSG_NOJMP;
						else if (!kbd_ok)
							msg_r <= MSG_LOCKED;
						else if (!in_rng)
							msg_r <= MSG_OOR;
						else
							msg_r <= MSG_STORED;
					end else if (kst_r == ST_IDLE && kc == K_NEXT) begin
						sel_r <= (sel_r == SW'(NSP - 1)) ? '0 : sel_r + 1'b1;
					end else if (kst_r == ST_IDLE && kc == K_PASS) begin
						kst_r  <= ST_PASS;
						msg_r  <= MSG_PASS;
						pbuf_r <= '0;
						pcnt_r <= 4'h0;
					end
				end
				ST_PASS: if (key_v) begin
					// first character lands in the low byte; keys past eight are ignored
					if (is_dig && pcnt_r < 4'(PASS_CHARS)) begin
						pbuf_r[8*pcnt_r +: 8] <= ASCII_ZERO + 8'(kc[3:0]);
						pcnt_r                <= pcnt_r + 4'h1;
					end else if (kc == K_ENTER) begin
						kst_r <= grant[IF_KBD] ? ST_IDLE : ST_FLASH;
						msg_r <= grant[IF_KBD] ? MSG_NORMAL : MSG_PASS_BAD;
						tmr_r <= 16'(FLASH_P - 1);
					end else if (kc == K_ESC) begin
						kst_r <= ST_IDLE;
						msg_r <= MSG_NORMAL;
					end
				end
				ST_FLASH: if (tick_r) begin
					if (tmr_r == 16'h0) begin
						kst_r <= ST_IDLE;
						msg_r <= MSG_NORMAL;
					end else begin
						tmr_r <= tmr_r - 16'h1;
					end
				end
				ST_HELP: begin
					if ((key_v && kc == K_ESC)
						|| (tick_r && tmr_r == 16'h0 && msg_r == MSG_H_STORE)) begin
						kst_r <= hret_r ? ST_EDIT : ST_IDLE;
						msg_r <= hret_r ? MSG_EDIT : MSG_NORMAL;
					end else if (tick_r && tmr_r == 16'h0) begin
						msg_r <= sea_msg_t'(msg_r + 4'h1);
						tmr_r <= 16'(HELP_P - 1);
					end else if (tick_r) begin
						tmr_r <= tmr_r - 16'h1;
					end
				end
				default: begin
					kst_r <= ST_IDLE;
					msg_r <= MSG_NORMAL;
				end
			endcase
		end
	end

	// display follows the editor one cycle later
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			disp_r <= '0;
		end else if (kst_r == ST_EDIT) begin
			disp_r <= edit_r;
		end else if (kst_r == ST_HELP && msg_r == MSG_H_MIN) begin
			disp_r <= cmin;
		end else if (kst_r == ST_HELP && msg_r == MSG_H_MAX) begin
			disp_r <= cmax;
		end else if (kst_r == ST_HELP && msg_r == MSG_H_STEP) begin
			disp_r <= cstep;
		end else begin
			disp_r <= cur;
		end
	end

	assign pready_o   = pready_r;
	assign prdata_o   = prdata_r;
	assign pslverr_o  = pslverr_r;
	assign disp_val_o = disp_r;
	assign msg_o      = msg_r;
	assign sel_o      = sel_r;
	assign kbd_acc_o  = acc_f_r[IF_KBD];
	assign com_acc_o  = acc_f_r[IF_COM];

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	property p_jmp;
		kst_r == ST_EDIT && k_ent && !jumper_i && !apb_wr
			|=> msg_r == MSG_NOJMP && $stable(sp_o);
	endproperty
	a_jmp: assert property (p_jmp) else $error("store taken without jumper");

	property p_com_jmp;
		apb_wr && sp_hit && pass_def && !jumper_i && wrng |-> !pslverr_r;
	endproperty
	a_com_jmp: assert property (p_com_jmp) else $error("jumper gated bus write");

	property p_com_lock;
		apb_wr && sp_hit && !pass_def && !acc_f_r[IF_COM] |-> pslverr_r;
	endproperty
	a_com_lock: assert property (p_com_lock) else $error("locked bus write taken");

	property p_iso;
		grant[IF_KBD] && !grant[IF_COM] && !acc_f_r[IF_COM] |=> !acc_f_r[IF_COM];
	endproperty
	a_iso: assert property (p_iso) else $error("keypad grant leaked to bus");

	property p_rev;
		revoke[IF_COM] |=> !acc_f_r[IF_COM] ##1 !acc_f_r[IF_COM] || grant[IF_COM];
	endproperty
	a_rev: assert property (p_rev) else $error("bad passcode kept access");

	property p_to;
		tick_r && !act[IF_KBD] && !grant[IF_KBD] && idle_r[IF_KBD] == TOW'(TIMEOUT_P - 1)
			|=> !acc_f_r[IF_KBD];
	endproperty
	a_to: assert property (p_to) else $error("idle timeout missed");

	property p_esc;
		kst_r == ST_EDIT && key_v && kc == K_ESC |=> kst_r == ST_IDLE ##1 disp_r == $past(cur);
	endproperty
	a_esc: assert property (p_esc) else $error("escape kept edit");

	property p_up;
		(kst_r == ST_IDLE || kst_r == ST_EDIT) && key_v && kc == K_UP && up_v > {1'b0, cmax}
			|=> edit_r == cmin;
	endproperty
	a_up: assert property (p_up) else $error("up did not wrap");

	property p_dn;
		kst_r == ST_EDIT && key_v && kc == K_DOWN && dn_wr |=> edit_r == cmax;
	endproperty
	a_dn: assert property (p_dn) else $error("down did not wrap");

	property p_pend;
		kst_r == ST_EDIT && key_v && kc != K_ENTER && !apb_wr |=> $stable(sp_o);
	endproperty
	a_pend: assert property (p_pend) else $error("edit stored before enter");

	property p_oor;
		kst_r == ST_EDIT && k_ent && jumper_i && kbd_ok && !in_rng && !apb_wr
			|=> msg_r == MSG_OOR && $stable(sp_o);
	endproperty
	a_oor: assert property (p_oor) else $error("out of range value stored");

	property p_rnd;
		kst_store |=> sp_r[$past(sel_r)] == $past(rnd[W-1:0]) && msg_r == MSG_STORED
			&& kst_r == ST_FLASH;
	endproperty
	a_rnd: assert property (p_rnd) else $error("rounded store wrong");

	c_store: cover property (kst_store);
	c_help:  cover property (kst_r == ST_HELP && msg_r == MSG_H_STORE);
	c_grant: cover property (grant[IF_COM]);
	c_wrap:  cover property (kst_r inside {ST_IDLE, ST_EDIT} && key_v && kc == K_UP
		&& up_v > {1'b0, cmax});
endmodule

// file: verilog/sea_pkg.sv
// sea_pkg: constants and types for the setpoint edit and access block
package sea_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 1000000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam int TIMEOUT_MIN   = 30;
	localparam int TIMEOUT_MS    = TIMEOUT_MIN * 60 * 1000;
	localparam int FLASH_MS      = 1000;
	localparam int HELP_MS       = 2000;
	localparam int PASS_CHARS    = 8;
	localparam int FRAC_DIGITS   = 2;
	localparam int N_IF          = 2;
	localparam int IF_KBD        = 0;
	localparam int IF_COM        = 1;
	// passcode is ASCII, first character in the low byte; "0" is the default
	localparam logic [8*PASS_CHARS-1:0] PASS_DEFAULT = 64'h0000_0000_0000_0030;
	localparam logic [7:0]  ASCII_ZERO = 8'h30;
	localparam logic [11:0] A_ENA_LO   = 12'h000;
	localparam logic [11:0] A_ENA_HI   = 12'h004;
	localparam logic [11:0] A_CODE_LO  = 12'h008;
	localparam logic [11:0] A_CODE_HI  = 12'h00C;
	localparam logic [11:0] A_STATUS   = 12'h010;
	localparam logic [3:0]  A_SP_PAGE  = 4'h1;
	localparam int SB_JMP  = 0;
	localparam int SB_DEF  = 1;
	localparam int SB_KACC = 2;
	localparam int SB_CACC = 3;
	localparam logic [4:0] K_9     = 5'h09;
	localparam logic [4:0] K_DOT   = 5'h0A;
	localparam logic [4:0] K_UP    = 5'h0B;
	localparam logic [4:0] K_DOWN  = 5'h0C;
	localparam logic [4:0] K_ENTER = 5'h0D;
	localparam logic [4:0] K_ESC   = 5'h0E;
	localparam logic [4:0] K_HELP  = 5'h0F;
	localparam logic [4:0] K_NEXT  = 5'h10;
	localparam logic [4:0] K_PASS  = 5'h11;
	localparam logic [4:0] K_LOCK  = 5'h12;

	typedef struct packed {
		logic       valid;
		logic [4:0] code;
	} sea_key_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_EDIT  = 3'b001,
		ST_PASS  = 3'b010,
		ST_FLASH = 3'b011,
		ST_HELP  = 3'b100
	} sea_st_t;

	typedef enum logic [3:0] {
		MSG_NORMAL   = 4'h0,
		MSG_EDIT     = 4'h1,
		MSG_STORED   = 4'h2,
		MSG_NOJMP    = 4'h3,
		MSG_LOCKED   = 4'h4,
		MSG_OOR      = 4'h5,
		MSG_PASS     = 4'h6,
		MSG_PASS_BAD = 4'h7,
		MSG_H_MIN    = 4'h8,
		MSG_H_MAX    = 4'h9,
		MSG_H_STEP   = 4'hA,
		MSG_H_EDIT   = 4'hB,
		MSG_H_STORE  = 4'hC
	} sea_msg_t;
endpackage

// file: test/sea_keypad.sv
// sea_keypad: front-panel operator model issuing one-cycle key pulses
`timescale 1ns/1ps
module sea_keypad import sea_pkg::*; (
	output sea_key_t   key_o,
	input  wire logic  clock_i
);
	initial key_o = '{valid: 1'b0, code: 5'h00};
	// code lines carry junk between presses, never the last code
	task press(input logic [4:0] c);
		@(posedge clock_i);
		key_o <= '{valid: 1'b1, code: c};
		@(posedge clock_i);
		key_o <= '{valid: 1'b0, code: ~c};
	endtask
	task give_pass(input logic [4:0] d0, input logic [4:0] d1);
		press(K_PASS);
		press(d0);
		press(d1);
		press(K_ENTER);
	endtask
endmodule

// file: test/setpoint_edit_access_bench.sv
// setpoint_edit_access_bench: self-checking bench for the setpoint editor
`timescale 1ns/1ps
module setpoint_edit_access_bench import sea_pkg::*;;
	localparam int W = 24;
	logic            clock_i = 1'b0;
	logic            nrst_i;
	logic            psel_i;
	logic            penable_i;
	logic            pwrite_i;
	logic            jumper_i;
	logic [11:0]     paddr_i;
	logic [31:0]     pwdata_i;
	logic [31:0]     prdata_o;
	logic            pready_o;
	logic            pslverr_o;
	logic            kbd_acc_o;
	logic            com_acc_o;
	sea_key_t        key_i;
	logic [W-1:0]    disp_val_o;
	sea_msg_t        msg_o;
	logic [1:0]      sel_o;
	logic [4*W-1:0]  sp_o;
	int              n_fail = 0;
	int              tests_run = 0;
	int              seed = 87;
	logic [32:0]     notes[$];
	logic [4:0]      dig[4] = '{5'h06, 5'h03, K_DOT, 5'h09};
	logic [W-1:0]    dval[4] = '{24'h000258, 24'h00189C, 24'h00189C, 24'h0018F6};
	logic [4:0]      rnd[5] = '{5'h06, 5'h09, K_DOT, 5'h02, 5'h08};

	always #5 clock_i = ~clock_i;

	sea_edit #(
		.MIN_P({4{24'h000064}}), .MAX_P({4{24'h002710}}),
		.INIT_P({4{24'h002710}}), .ENUM_P(4'h8), .TICK_CYC_P(4), .TIMEOUT_P(5),
		.FLASH_P(2), .HELP_P(2)
	) u_sea_edit (
		.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
		.prdata_o(prdata_o), .pslverr_o(pslverr_o), .key_i(key_i), .jumper_i(jumper_i),
		.disp_val_o(disp_val_o), .msg_o(msg_o), .sel_o(sel_o), .sp_o(sp_o),
		.kbd_acc_o(kbd_acc_o), .com_acc_o(com_acc_o)
	);
	sea_keypad u_sea_keypad (.key_o(key_i), .clock_i(clock_i));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task print_verdict();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
		int n;
		n = 0;
		notes.push_back(exp);
		@(posedge clock_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1 && n++ < 40);
		if (pready_o !== 1'b1)
			n_fail++;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d, {e, 32'h0});
	endtask
	task rd(input logic [11:0] a, input logic [31:0] v);
		apb(1'b0, a, 32'h0, {1'b0, v});
	endtask
	task idle(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// three edges let msg and the lagging display settle
	task key(input logic [4:0] c);
		u_sea_keypad.press(c);
		idle(3);
	endtask

	// each answer is paired with the oldest note
	always @(posedge clock_i) begin
		if (pready_o === 1'b1) begin
			check({pslverr_o, prdata_o}, notes.size() ? notes.pop_front() : 33'h1FFFFFFFF);
		end
	end

	initial begin
		#300000;
		n_fail++;
		print_verdict();
	end

	initial begin
		logic [31:0] v;
		logic [31:0] last;
		logic        e;
		int          n;
		nrst_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		jumper_i = 1'b1;
		last = 32'h00002710;
		n = 0;
		idle(8);
		nrst_i <= 1'b1;
		rd(A_STATUS, 32'h00000003);
		rd(12'h100, 32'h00002710);
		wr(12'hFFC, 32'h0, 1'b1);
		foreach (dig[i]) begin
			key(dig[i]);
			check(disp_val_o, dval[i]);
		end
		rd(12'h100, 32'h00002710);
		key(K_ESC);
		check(disp_val_o, 24'h002710);
		foreach (rnd[i]) key(rnd[i]);
		key(K_ENTER);
		check(msg_o, MSG_STORED);
		check(sp_o[W-1:0], 24'h001B12);
		idle(16);
		check(msg_o, MSG_NORMAL);
		key(5'h01);
		key(5'h02);
		key(5'h03);
		key(K_ENTER);
		check(msg_o, MSG_OOR);
		check(sp_o[W-1:0], 24'h001B12);
		idle(16);
		key(K_NEXT);
		check(sel_o, 2'h1);
		key(K_UP);
		check(disp_val_o, 24'h000064);
		key(K_DOWN);
		check(disp_val_o, 24'h002710);
		key(K_DOWN);
		check(disp_val_o, 24'h002706);
		key(K_ESC);
		jumper_i <= 1'b0;
		key(5'h05);
		key(K_ENTER);
		check(msg_o, MSG_NOJMP);
		idle(16);
		wr(12'h104, 32'h000007D0, 1'b0);
		rd(12'h104, 32'h000007D0);
		jumper_i <= 1'b1;
		key(K_HELP);
		check(msg_o, MSG_H_MIN);
		check(disp_val_o, 24'h000064);
		while (msg_o !== MSG_H_MAX && n++ < 30) @(posedge clock_i);
		idle(2);
		check(disp_val_o, 24'h002710);
		key(K_ESC);
		wr(A_CODE_LO, 32'h00003837, 1'b0);
		wr(A_CODE_HI, 32'h0, 1'b0);
		rd(A_STATUS, 32'h00000001);
		wr(12'h104, 32'h00000BB8, 1'b1);
		key(5'h05);
		key(K_ENTER);
		check(msg_o, MSG_LOCKED);
		idle(16);
		u_sea_keypad.give_pass(5'h08, 5'h07);
		idle(2);
		check(msg_o, MSG_PASS_BAD);
		check(kbd_acc_o, 1'b0);
		idle(16);
		u_sea_keypad.give_pass(5'h07, 5'h08);
		idle(3);
		check({kbd_acc_o, com_acc_o}, 2'b10);
		key(5'h05);
		key(K_ENTER);
		check(sp_o[2*W-1:W], 24'h0001F4);
		check(kbd_acc_o, 1'b1);
		key(K_LOCK);
		check(kbd_acc_o, 1'b0);
		idle(16);
		wr(12'h104, 32'h00000BB8, 1'b1);
		wr(A_ENA_LO, 32'h00003837, 1'b0);
		wr(A_ENA_HI, 32'h0, 1'b0);
		idle(2);
		check(com_acc_o, 1'b1);
		repeat (4) begin
			v = $random(seed) & 32'h00003FFF;
			e = v < 32'd100 || v > 32'd10000;
			wr(12'h108, v, e);
			last = e ? last : v;
			rd(12'h108, last);
		end
		wr(A_ENA_LO, 32'h00000038, 1'b0);
		wr(A_ENA_HI, 32'h0, 1'b0);
		idle(2);
		check(com_acc_o, 1'b0);
		key(K_LOCK);
		check(kbd_acc_o, 1'b0);
		wr(A_ENA_LO, 32'h00003837, 1'b0);
		wr(A_ENA_HI, 32'h0, 1'b0);
		repeat (6) begin
			idle(6);
			rd(A_STATUS, 32'h00000009);
		end
		idle(40);
		check(com_acc_o, 1'b0);
		key(K_NEXT);
		key(K_NEXT);
		key(5'h05);
		check(disp_val_o, 24'h002710);
		key(K_UP);
		check(disp_val_o, 24'h000064);
		key(K_ESC);
		idle(4);
		check(notes.size(), 0);
		print_verdict();
	end
endmodule
